// >>> i2c_nv_pkg.sv
package i2c_nv_pkg;

  // Array geometry.
  localparam int MEM_ADDR_W = 17;
  localparam int BYTE_W     = 8;

  // Slave address byte layout.
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam int         DEV_TYPE_HI   = 7;
  localparam int         DEV_TYPE_LO   = 4;
  localparam int         DEV_SEL_HI    = 3;
  localparam int         DEV_SEL_LO    = 2;
  localparam int         PAGE_BIT      = 1;
  localparam int         RW_BIT        = 0;

  // Address split: page bit on top, then high and low address bytes.
  localparam int ADDR_HI_MSB = 15;
  localparam int ADDR_HI_LSB = 8;
  localparam int ADDR_LO_MSB = 7;

  // Bit counter values within one byte slot.
  localparam logic [3:0] CNT_ZERO     = 4'h0;
  localparam logic [3:0] CNT_LAST_BIT = 4'h7;
  localparam logic [3:0] CNT_ACK_SLOT = 4'h8;

  // Identification value width; its content is a module parameter.
  localparam int PART_ID_W = 24;

  // Protocol phases, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_DEVADDR = 6'h02,
    ST_ADDR_HI = 6'h04,
    ST_ADDR_LO = 6'h08,
    ST_WRITE   = 6'h10,
    ST_READ    = 6'h20
  } phase_t;

  // One byte bound for the array, with its location.
  typedef struct packed {
    logic [MEM_ADDR_W-1:0] addr;
    logic [BYTE_W-1:0]     data;
  } wr_req_t;

endpackage

// >>> two_entry_buffer.sv
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int W = 8
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int         DEPTH = 2;
  localparam logic [1:0] FULL  = 2'h2;

  logic [W-1:0] slot_r [0:DEPTH-1];
  logic         wr_ptr_r;
  logic         rd_ptr_r;
  logic [1:0]   count_r;
  logic         push;
  logic         pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_o  = (count_r != FULL);
  assign out_valid_o = (count_r != 2'h0);
  assign out_data_o  = slot_r[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointers and count; a push and a pop together leave the count alone.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else if (ce_i) begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      if (push && !pop) begin
        count_r <= count_r + 2'h1;
      end else if (pop && !push) begin
        count_r <= count_r - 2'h1;
      end
    end
  end

  // Storage needs no reset since nothing reads an empty slot.
  always_ff @(posedge mclk_i) begin
    if (ce_i && push) begin
      slot_r[wr_ptr_r] <= in_data_i;
    end
  end

endmodule

// >>> i2c_nv_byte_memory.sv
// Notes on behaviour
// (R1) Answer a slave address only when its select bits equal the select pins.
// (R2) Select pins are pulled low at the pad; open pins read as zero.
// (R3) Data line is only pulled low or released; never driven high.
// (R4) Output bits change after falling clock edges; inputs sampled on rising edges.
// (R5) Write-protect high blocks all writes; low allows all writes.
// (R6) Write-protect pin is pulled low at the pad, so open means writable.
// (R7) Array holds 131072 bytes, each shifted serially in or out.
// (R8) Address is page bit on top, then high byte, then low byte.
// (R9) Each received byte is committed at once; the device never reports busy.
// (R10) Works at 100 kHz, 400 kHz and high-speed up to 3.4 MHz.
// (R11) A read-only identification value is held in the device.
// (R12) Slave byte: type 1010 in 7..4, select 3..2, page 1, read 0.
// (R13) Address advances after each byte, before the acknowledge, wrapping to zero.
// (R14) After eight bits the sender releases; receiver acknowledges low; no-ack ends.
// (R15) A start or stop mid-operation aborts it and awaits a slave address.
// (R16) Under write protection bytes are still acknowledged and the address advances.
`timescale 1ns/1ps
module i2c_nv_byte_memory
  import i2c_nv_pkg::*;
#(
  parameter int                   ADDR_W  = MEM_ADDR_W,
  parameter logic [PART_ID_W-1:0] PART_ID = 24'h5a5a01 // Arbitrary neutral value.
) (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 ce_i,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_o,
  input  wire logic [1:0]           device_select_pins_i,
  input  wire logic                 wp_i,
  output logic                      addressed_o,
  output logic                      write_blocked_o,
  output logic [ADDR_W-1:0]         cur_addr_o,
  output logic [PART_ID_W-1:0]      part_identifier_o
);

  localparam int          DEPTH    = 1 << ADDR_W;
  localparam logic [ADDR_W-1:0] ADDR_ONE = {{(ADDR_W-1){1'b0}}, 1'b1};

  logic                 rst_m_r;
  logic                 rst_n;
  logic                 scl_m_r, scl_s_r, scl_d_r;
  logic                 sda_m_r, sda_s_r, sda_d_r;
  logic                 wp_m_r, wp_s_r;
  logic [1:0]           sel_m_r, sel_s_r;
  phase_t               phase_r;
  logic [3:0]           cnt_r;
  logic                 ack_r;
  logic                 rw_r;
  logic                 nack_r;
  logic                 drive_low_r;
  logic [BYTE_W-1:0]    shift_r;
  logic [BYTE_W-1:0]    tx_r;
  logic [BYTE_W-1:0]    rd_q_r;
  logic                 fetch_r;
  logic [ADDR_W-1:0]    addr_r;
  logic                 pend_r;
  wr_req_t              pend_req_r;
  logic [PART_ID_W-1:0] part_id_r;
  logic [BYTE_W-1:0]    mem [0:DEPTH-1]; // (R7)

  logic              scl_rise, scl_fall, start_ev, stop_ev;
  logic              active, byte_in, ack_start, ack_end, dev_match;
  logic [BYTE_W-1:0] rx_byte;
  logic              buf_in_ready, buf_out_valid;
  wr_req_t           buf_out;

  // Reset is asserted at once and released two clocks later.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_m_r <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n   <= rst_m_r;
    end
  end

  // Pins come from the master's timing, so each passes two flops first.
  // The third scl and sda stage is only for edge finding.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
      {wp_m_r, wp_s_r}            <= 2'h0;
      sel_m_r                     <= 2'h0;
      sel_s_r                     <= 2'h0;
    end else if (ce_i) begin
      {scl_m_r, scl_s_r, scl_d_r} <= {scl_i, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_d_r} <= {sda_i, sda_m_r, sda_s_r};
      {wp_m_r, wp_s_r}            <= {wp_i, wp_m_r};
      sel_m_r                     <= device_select_pins_i; // (R2)
      sel_s_r                     <= sel_m_r;
    end
  end

  // Bus events. Start and stop are sda moving while scl stays high.
  // Both lines share one synchroniser depth, so their order is kept as long
  // as the master holds sda at least one clock past the falling scl edge.
  assign scl_rise  = scl_s_r & ~scl_d_r;
  assign scl_fall  = ~scl_s_r & scl_d_r;
  assign start_ev  = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_ev   = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  assign active    = (phase_r != ST_IDLE);
  assign rx_byte   = {shift_r[BYTE_W-2:0], sda_s_r};
  assign byte_in   = scl_rise & ~ack_r & active & (phase_r != ST_READ) & (cnt_r == CNT_LAST_BIT);
  assign ack_start = scl_fall & ~ack_r & active & (cnt_r == CNT_ACK_SLOT);
  assign ack_end   = scl_fall & ack_r;
  assign dev_match = (rx_byte[DEV_TYPE_HI:DEV_TYPE_LO] == DEV_TYPE_CODE) &&
                     (rx_byte[DEV_SEL_HI:DEV_SEL_LO] == sel_s_r); // (R1) (R12)

  // Protocol phase, bit count and acknowledge slot tracking.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= ST_IDLE;
      cnt_r   <= CNT_ZERO;
      ack_r   <= 1'b0;
      rw_r    <= 1'b0;
      nack_r  <= 1'b0;
    end else if (ce_i) begin
      if (start_ev) begin
        phase_r <= ST_DEVADDR; // (R15)
        cnt_r   <= CNT_ZERO;
        ack_r   <= 1'b0;
      end else if (stop_ev) begin
        phase_r <= ST_IDLE; // (R15)
        ack_r   <= 1'b0;
      end else if (active) begin
        if (scl_rise && !ack_r && cnt_r != CNT_ACK_SLOT) begin
          cnt_r <= cnt_r + 4'h1;
        end
        if (scl_rise && ack_r && phase_r == ST_READ) begin
          nack_r <= sda_s_r; // (R14)
        end
        // A foreign address, including a high-speed master code, is not answered.
        if (byte_in && phase_r == ST_DEVADDR) begin
          rw_r <= rx_byte[RW_BIT];
          if (!dev_match) begin
            phase_r <= ST_IDLE; // (R1)
          end
        end
        if (ack_start) begin
          ack_r <= 1'b1;
        end
        if (ack_end) begin
          ack_r <= 1'b0;
          cnt_r <= CNT_ZERO;
          case (phase_r)
            ST_DEVADDR: phase_r <= rw_r ? ST_READ : ST_ADDR_HI;
            ST_ADDR_HI: phase_r <= ST_ADDR_LO;
            ST_ADDR_LO: phase_r <= ST_WRITE;
            ST_WRITE:   phase_r <= ST_WRITE;
            ST_READ:    phase_r <= nack_r ? ST_IDLE : ST_READ; // (R14)
            default:    phase_r <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // Incoming bits are taken on the rising scl edge.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= '0;
    end else if (ce_i && scl_rise && !ack_r) begin
      shift_r <= rx_byte; // (R4)
    end
  end

  // Address latch. It is loaded from the address bytes and steps once per
  // byte, before the acknowledge, wrapping from the top back to zero.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= '0;
    end else if (ce_i && !start_ev && !stop_ev) begin
      if (byte_in) begin
        case (phase_r)
          ST_DEVADDR: if (dev_match && !rx_byte[RW_BIT]) addr_r[ADDR_W-1] <= rx_byte[PAGE_BIT]; // (R8)
          ST_ADDR_HI: addr_r[ADDR_HI_MSB:ADDR_HI_LSB] <= rx_byte; // (R8)
          ST_ADDR_LO: addr_r[ADDR_LO_MSB:0] <= rx_byte; // (R8)
          ST_WRITE:   addr_r <= addr_r + ADDR_ONE; // (R13) (R16)
          default:    addr_r <= addr_r;
        endcase
      end else if (ack_start && phase_r == ST_READ) begin
        addr_r <= addr_r + ADDR_ONE; // (R13)
      end
    end
  end

  // Data line drive. Only a low level is ever put on the wire, and every
  // change happens on a falling scl edge, except the release on a start or stop.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      drive_low_r <= 1'b0;
      tx_r        <= '0;
    end else if (ce_i) begin
      if (start_ev || stop_ev) begin
        drive_low_r <= 1'b0; // (R15)
      end else if (ack_start) begin
        drive_low_r <= (phase_r != ST_READ); // (R14)
      end else if (ack_end) begin
        if ((phase_r == ST_DEVADDR && rw_r) || (phase_r == ST_READ && !nack_r)) begin
          tx_r        <= rd_q_r;
          drive_low_r <= ~rd_q_r[BYTE_W-1]; // (R4)
        end else begin
          drive_low_r <= 1'b0;
        end
      end else if (scl_fall && phase_r == ST_READ && !ack_r && cnt_r != CNT_ZERO) begin
        tx_r        <= {tx_r[BYTE_W-2:0], 1'b0};
        drive_low_r <= ~tx_r[BYTE_W-2]; // (R4)
      end
    end
  end

  // A fetch is requested at the acknowledge that precedes each sent byte; after
  // the first, it comes one clock after the address step, so it reads the new location.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      fetch_r <= 1'b0;
    end else if (ce_i) begin
      fetch_r <= ack_start & ((phase_r == ST_DEVADDR && rw_r) || phase_r == ST_READ);
    end
  end

  // A received byte waits here until the buffer takes it. Protected writes
  // are dropped here, after the acknowledge and address step were decided.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_r     <= 1'b0;
      pend_req_r <= '0;
    end else if (ce_i) begin
      if (byte_in && phase_r == ST_WRITE && !start_ev && !stop_ev && !wp_s_r) begin // (R5) (R16)
        pend_r          <= 1'b1; // (R9)
        pend_req_r.addr <= addr_r;
        pend_req_r.data <= rx_byte;
      end else if (buf_in_ready) begin
        pend_r <= 1'b0;
      end
    end
  end

  // The array port serves fetches first; the buffer absorbs the stall, and a
  // byte arrives only every nine scl periods, so two entries never overflow.
  two_entry_buffer #(
    .W($bits(wr_req_t))
  ) u_wr_buf (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n),
    .ce_i        (ce_i),
    .in_valid_i  (pend_r),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (pend_req_r),
    .out_valid_o (buf_out_valid),
    .out_ready_i (~fetch_r),
    .out_data_o  (buf_out)
  );

  // Single-port array. No reset, as it stands for nonvolatile contents.
  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      if (fetch_r) begin
        rd_q_r <= mem[addr_r]; // (R7)
      end else if (buf_out_valid) begin
        mem[buf_out.addr[ADDR_W-1:0]] <= buf_out.data; // (R9)
      end
    end
  end

  // Identification value, held read-only from reset on.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      part_id_r <= PART_ID; // (R11)
    end else begin
      part_id_r <= PART_ID;
    end
  end

  // Open-drain pin: output value is always low, the enable does the work.
  // Sampling at 25 MHz gives about seven clocks per high-speed bit, which
  // is enough for the edge logic above but leaves little margin. (R10)
  assign sda_o             = 1'b0; // (R3)
  assign sda_oe_o          = drive_low_r; // (R3)
  assign addressed_o       = active;
  assign write_blocked_o   = wp_s_r; // (R6)
  assign cur_addr_o        = addr_r;
  assign part_identifier_o = part_id_r;

endmodule

// >>> i2c_nv_byte_memory_checker.sv
`timescale 1ns/1ps
module i2c_nv_byte_memory_checker
  import i2c_nv_pkg::*;
#(
  parameter int                   ADDR_W  = MEM_ADDR_W,
  parameter logic [PART_ID_W-1:0] PART_ID = 24'h000000
) (
  input wire logic                 mclk_i,
  input wire logic                 rst_b_i,
  input wire logic                 ce_i,
  input wire logic                 scl_i,
  input wire logic                 sda_i,
  input wire logic                 sda_o,
  input wire logic                 sda_oe_o,
  input wire logic [1:0]           device_select_pins_i,
  input wire logic                 wp_i,
  input wire logic                 addressed_o,
  input wire logic                 write_blocked_o,
  input wire logic [ADDR_W-1:0]    cur_addr_o,
  input wire logic [PART_ID_W-1:0] part_identifier_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  // A low drive must outlast the master's sampling point in the high phase.
  sequence low_held;
    sda_oe_o [*6];
  endsequence

  // Open drain, launched in the low phase, held, and only while a transfer is open.
  sda_zero_a: assert property (sda_o == 1'b0) else $error("data line driven high");
  drive_on_low_a: assert property ($rose(sda_oe_o) |-> !$past(scl_i, 2))
    else $error("data drive began outside the clock low phase");
  ack_held_a: assert property ($rose(sda_oe_o) |-> low_held) else $error("low drive too short");
  drive_when_sel_a: assert property ($rose(sda_oe_o) |-> addressed_o)
    else $error("data driven while not addressed");
  quiet_idle_a: assert property (!addressed_o && !$past(addressed_o) |-> !sda_oe_o)
    else $error("data driven while idle");
  // Protection level is a short synchroniser away from the pin.
  wp_on_a: assert property ($rose(wp_i) |-> ##[1:4] write_blocked_o) else $error("protect not seen");
  wp_off_a: assert property ($fell(wp_i) |-> ##[1:4] !write_blocked_o) else $error("protect stuck");
  id_fixed_a: assert property (part_identifier_o == PART_ID) else $error("identifier changed");
  addr_idle_a: assert property ($changed(cur_addr_o) |-> $past(addressed_o))
    else $error("address moved outside a transfer");
endmodule

bind i2c_nv_byte_memory i2c_nv_byte_memory_checker #(.ADDR_W(ADDR_W), .PART_ID(PART_ID)) u_chk (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .device_select_pins_i(device_select_pins_i), .wp_i(wp_i),
  .addressed_o(addressed_o), .write_blocked_o(write_blocked_o), .cur_addr_o(cur_addr_o),
  .part_identifier_o(part_identifier_o)
);

// >>> i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
  output logic      scl_o,
  output logic      sda_drv_o,
  input  wire logic sda_i
);
  // Bus idles with the clock high and the data line released.
  initial begin
    scl_o = 1'b1;
    sda_drv_o = 1'b0;
  end

  // One 320 ns slot; data moves 40 ns after the fall so it never races the clock.
  task bit_x(input logic b, output logic r);
    #40 sda_drv_o = ~b;
    #120 scl_o = 1'b1;
    #80 r = sda_i;
    #80 scl_o = 1'b0;
  endtask

  // Data falls while the clock is high; also serves as a repeated start.
  task start_c();
    #40 sda_drv_o = 1'b0;
    #120 scl_o = 1'b1;
    #80 sda_drv_o = 1'b1;
    #80 scl_o = 1'b0;
  endtask

  // Data rises while the clock is high, leaving the bus idle.
  task stop_c();
    #40 sda_drv_o = 1'b1;
    #120 scl_o = 1'b1;
    #80 sda_drv_o = 1'b0;
    #80;
  endtask

  // Most significant bit first, then the released slot for the acknowledge.
  task wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  // A nack on the last byte tells the device to let go of the line.
  task rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~ack, r);
  endtask
endmodule

// >>> i2c_nv_byte_memory_tb.sv
`timescale 1ns/1ps
module i2c_nv_byte_memory_tb;
  import i2c_nv_pkg::*;
  localparam logic [PART_ID_W-1:0] ID = 24'h3c1e07; // Arbitrary neutral value.
  localparam logic [7:0] PAT [3] = '{8'ha5, 8'h3c, 8'h81};
  logic        mclk_i;
  logic        rst_b_i;
  logic        wp_i;
  logic        ce;
  logic        scl;
  logic        mdrv;
  logic        sda_o;
  logic        sda_oe_o;
  logic        addressed_o;
  logic        write_blocked_o;
  logic        ack;
  logic [1:0]  sel;
  logic [1:0]  s;
  logic [7:0]  d;
  logic [16:0] cur_addr_o;
  logic [23:0] part_identifier_o;
  int          n_mismatch = 0;
  int          total_checks = 0;
  // Pull-up wins unless some party pulls low.
  wire sda = !(sda_oe_o || mdrv);

  i2c_nv_byte_memory #(.PART_ID(ID)) u_dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .device_select_pins_i(sel), .wp_i(wp_i), .addressed_o(addressed_o),
    .write_blocked_o(write_blocked_o), .cur_addr_o(cur_addr_o), .part_identifier_o(part_identifier_o)
  );
  i2c_master_model u_mst (.scl_o(scl), .sda_drv_o(mdrv), .sda_i(sda));

  // 25 MHz system clock.
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  task give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [23:0] g, input logic [23:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // Opens a write transfer and loads a full address.
  task wr_addr(input logic [16:0] a);
    u_mst.start_c();
    u_mst.wr_byte({DEV_TYPE_CODE, sel, a[16], 1'b0}, ack);
    chk({23'h0, ack}, 24'h1, "slave ack");
    u_mst.wr_byte(a[15:8], ack);
    chk({23'h0, ack}, 24'h1, "address high ack");
    u_mst.wr_byte(a[7:0], ack);
    chk({23'h0, ack}, 24'h1, "address ack");
  endtask

  // Loads an address, then turns round with a repeated start into a read.
  task rd_at(input logic [16:0] a);
    wr_addr(a);
    u_mst.start_c();
    u_mst.wr_byte({DEV_TYPE_CODE, sel, a[16], 1'b1}, ack);
    chk({23'h0, ack}, 24'h1, "read slave ack");
  endtask

  // A hung transfer is cut short here.
  initial begin
    #3000000;
    n_mismatch++;
    $display("unexpected at %0t: run limit reached", $time);
    give_verdict();
  end

  initial begin
    rst_b_i = 1'b0;
    ce = 1'b1;
    wp_i = 1'b0;
    sel = 2'b10;
    repeat (16) @(posedge mclk_i);
    #1 rst_b_i = 1'b1;
    repeat (8) @(posedge mclk_i);
    #1;
    chk({23'h0, sda_oe_o}, 24'h0, "line released");
    chk({7'h0, cur_addr_o}, 24'h0, "address at reset");
    chk({23'h0, addressed_o}, 24'h0, "idle at reset");
    chk(part_identifier_o, ID, "identifier");
    $display("test reset done");
    // Three bytes across the top of the array, so the last one wraps.
    wr_addr(17'h1fffe);
    for (int i = 0; i < 3; i++) begin
      u_mst.wr_byte(PAT[i], ack);
      chk({23'h0, ack}, 24'h1, "data ack");
    end
    u_mst.stop_c();
    chk({7'h0, cur_addr_o}, 24'h000001, "wrapped address");
    rd_at(17'h1fffe);
    for (int i = 0; i < 3; i++) begin
      u_mst.rd_byte(i != 2, d);
      chk({16'h0, d}, {16'h0, PAT[i]}, "read back");
    end
    u_mst.stop_c();
    chk({23'h0, addressed_o}, 24'h0, "idle after nack");
    $display("test write and read done");
    // Protected write is acknowledged and advances, but leaves the byte.
    wp_i = 1'b1;
    repeat (6) @(posedge mclk_i);
    #1 chk({23'h0, write_blocked_o}, 24'h1, "protect seen");
    wr_addr(17'h1ffff);
    u_mst.wr_byte(8'h00, ack);
    chk({23'h0, ack}, 24'h1, "protected ack");
    u_mst.stop_c();
    // The stop needs a few clocks to pass the synchroniser before it ends the write.
    repeat (4) @(posedge mclk_i);
    #1 chk({23'h0, addressed_o}, 24'h0, "idle after write stop");
    chk({7'h0, cur_addr_o}, 24'h0, "protected advance");
    wp_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    #1 chk({23'h0, write_blocked_o}, 24'h0, "protect lifted");
    rd_at(17'h1ffff);
    u_mst.rd_byte(1'b0, d);
    chk({16'h0, d}, {16'h0, PAT[1]}, "byte kept");
    u_mst.stop_c();
    $display("test protect done");
    // Every select code against two strap settings, then a foreign type code.
    for (int k = 0; k < 8; k++) begin
      sel = k[2] ? 2'b01 : 2'b10;
      s = k[1:0];
      u_mst.start_c();
      u_mst.wr_byte({DEV_TYPE_CODE, s, 2'b00}, ack);
      chk({23'h0, ack}, {23'h0, s == sel}, "select match");
      u_mst.stop_c();
    end
    u_mst.start_c();
    u_mst.wr_byte({4'hb, sel, 2'b00}, ack);
    chk({23'h0, ack}, 24'h0, "foreign type");
    u_mst.stop_c();
    $display("test select done");
    // With the clock enable low the device is frozen, so a matching byte goes unanswered.
    repeat (4) @(posedge mclk_i);
    #1 ce = 1'b0;
    u_mst.start_c();
    u_mst.wr_byte({DEV_TYPE_CODE, sel, 2'b00}, ack);
    chk({23'h0, ack}, 24'h0, "frozen no ack");
    chk({23'h0, addressed_o}, 24'h0, "frozen idle");
    ce = 1'b1;
    u_mst.stop_c();
    $display("test freeze done");
    // A start in mid-byte abandons the address and takes a new slave byte.
    u_mst.start_c();
    u_mst.wr_byte({DEV_TYPE_CODE, sel, 2'b00}, ack);
    chk({23'h0, ack}, 24'h1, "ack before abort");
    for (int i = 0; i < 3; i++) u_mst.bit_x(1'b0, ack);
    u_mst.start_c();
    u_mst.wr_byte({DEV_TYPE_CODE, sel, 2'b01}, ack);
    chk({23'h0, ack}, 24'h1, "ack after abort");
    u_mst.rd_byte(1'b0, d);
    chk({16'h0, d}, {16'h0, PAT[2]}, "latch kept");
    u_mst.stop_c();
    repeat (4) @(posedge mclk_i);
    #1 chk({23'h0, addressed_o}, 24'h0, "idle after stop");
    $display("test abort done");
    give_verdict();
  end
endmodule
